// *** core/mmec_top.sv ***
// Monitor mode entry and control: strap latching, clock divide, watchdog hold,
// vector relocation, security byte wait and break handshake on one wired-OR pin.
// Assumes straps and the reset pin level arrive synchronous to clk.
`timescale 1ns/1ns
`include "mmec_regs.svh"
module mmec_top #(
  parameter int BIT_CYCLES = `MMEC_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on_reset,
  input wire logic reset_pin,
  input mmec_pkg::mmec_straps_t straps,
  input wire logic serial_link_pin_in,
  output logic serial_link_pin_out,
  output logic serial_link_pin_oe,
  output mmec_pkg::mmec_mode_t mode,
  output logic [15:0] reset_vector_addr,
  output logic [15:0] swi_vector_addr,
  output logic security_done,
  output logic command_ready,
  output logic [7:0] command_data,
  output logic command_valid
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bit_cycles_check
    $error("BIT_CYCLES out of range");
  end

  // ************************************************************
  // Entry latch
  // ************************************************************
  logic reset_pin_reg;
  logic mon_reg;
  logic blank_reg;
  logic [1:0] div_reg;
  logic pll_reg;
  wire logic reset_rise = reset_pin && !reset_pin_reg;
  wire logic strap_entry = straps.test_voltage_irq
    && straps.entry_select_a2 == `MMEC_ENTRY_A2
    && straps.entry_select_a1 == `MMEC_ENTRY_A1
    && serial_link_pin_in == `MMEC_ENTRY_LINK;
  wire logic blank_entry = !straps.test_voltage_irq && straps.reset_vector_blank;
  wire logic enter_now = strap_entry || blank_entry;
  wire logic [1:0] div_next = straps.test_voltage_irq
    ? (straps.clock_divider_select ? `MMEC_DIV_BY4 : `MMEC_DIV_BY2)
    : `MMEC_DIV_PLL;

  always_ff @(posedge clk) begin
    if (!reset_n || power_on_reset) begin
      reset_pin_reg <= 1'b0;
      mon_reg <= 1'b0;
      blank_reg <= 1'b0;
      div_reg <= `MMEC_DIV_BY4;
      pll_reg <= 1'b0;
    end else begin
      reset_pin_reg <= reset_pin;
      // Straps latch only at the release edge; later changes reach only the watchdog hold, through the test voltage straps.
      if (reset_rise && !blank_reg) begin
        mon_reg <= enter_now;
        blank_reg <= blank_entry;
        div_reg <= enter_now ? div_next : `MMEC_DIV_BY4;
        pll_reg <= blank_entry && straps.irq_low;
      end
    end
  end

  // ************************************************************
  // Clock and watchdog control
  // ************************************************************
  wire logic in_reset = !reset_pin;
  wire logic tv_any = straps.test_voltage_irq || straps.test_voltage_reset;
  assign mode.debug_monitor_mode = mon_reg;
  assign mode.blank_entry = blank_reg;
  assign mode.watchdog_disable = in_reset || (mon_reg && tv_any);
  assign mode.bus_clock_run = !in_reset;
  assign mode.clock_divide = in_reset ? `MMEC_DIV_STOP : div_reg;
  assign mode.pll_enable = pll_reg;

  // ************************************************************
  // Vector relocation
  // ************************************************************
  assign reset_vector_addr = mon_reg ? `MMEC_RESET_VEC_MON : `MMEC_RESET_VEC_USER;
  assign swi_vector_addr = mon_reg ? `MMEC_SWI_VEC_MON : `MMEC_SWI_VEC_USER;

  // ************************************************************
  // Serial link
  // ************************************************************
  wire logic [7:0] rx_data;
  wire logic rx_valid;
  wire logic rx_break;
  wire logic tx_busy;
  wire logic tx_low;
  logic tx_send_break_reg;
  // The receiver is blind while the device transmits, so its own break on the shared line is never a frame.
  wire logic rx_line = serial_link_pin_in || tx_busy;
  mmec_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .line_in(rx_line),
    .byte_data(rx_data),
    .byte_valid(rx_valid),
    .break_seen(rx_break)
  );
  mmec_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .clk(clk),
    .reset_n(reset_n),
    .send(1'b0),
    .send_break(tx_send_break_reg),
    .send_data(8'h00),
    .busy(tx_busy),
    .line_low(tx_low)
  );
  // Only a low is ever driven; a high comes from the pull-up.
  assign serial_link_pin_out = 1'b0;
  assign serial_link_pin_oe = tx_low;

  // ************************************************************
  // Security and break sequencer
  // ************************************************************
  mmec_pkg::mmec_state_t state_reg;
  mmec_pkg::mmec_state_t state_next;
  logic [3:0] sec_cnt_reg;
  logic [20:0] gap_reg;
  logic started_reg;
  logic [7:0] cmd_reg;
  logic cmd_valid_reg;
  wire logic active = mon_reg && reset_pin;
  wire logic gap_end = (gap_reg == 21'(`MMEC_ECHO_GAP_BITS * BIT_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mmec_pkg::MMEC_SEC: begin
        if (rx_valid && sec_cnt_reg == 4'(`MMEC_SEC_BYTES - 1))
          state_next = mmec_pkg::MMEC_TXBRK;
      end
      mmec_pkg::MMEC_TXBRK: begin
        if (started_reg && !tx_busy)
          state_next = mmec_pkg::MMEC_READY;
      end
      mmec_pkg::MMEC_READY: begin
        if (rx_break)
          state_next = mmec_pkg::MMEC_BRKGAP;
      end
      mmec_pkg::MMEC_BRKGAP: begin
        if (gap_end)
          state_next = mmec_pkg::MMEC_TXBRK;
      end
      default: state_next = mmec_pkg::MMEC_SEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !active) begin
      state_reg <= mmec_pkg::MMEC_SEC;
      sec_cnt_reg <= 4'h0;
      gap_reg <= 21'h000000;
      started_reg <= 1'b0;
      tx_send_break_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == mmec_pkg::MMEC_SEC && rx_valid)
        sec_cnt_reg <= sec_cnt_reg + 4'h1;
      gap_reg <= (state_reg == mmec_pkg::MMEC_BRKGAP) ? gap_reg + 21'h000001 : 21'h000000;
      tx_send_break_reg <= (state_reg == mmec_pkg::MMEC_TXBRK) && !started_reg && !tx_busy;
      if (state_reg != mmec_pkg::MMEC_TXBRK)
        started_reg <= 1'b0;
      else if (tx_busy)
        started_reg <= 1'b1;
    end
  end

  // Bytes are passed on only once the device is ready for commands.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_reg <= 8'h00;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= rx_valid && active && state_reg == mmec_pkg::MMEC_READY;
      if (rx_valid)
        cmd_reg <= rx_data;
    end
  end

  assign security_done = active && state_reg != mmec_pkg::MMEC_SEC;
  assign command_ready = active && state_reg == mmec_pkg::MMEC_READY;
  assign command_data = cmd_reg;
  assign command_valid = cmd_valid_reg;
endmodule : mmec_top

// *** shared/mmec_regs.svh ***
// Constants for the monitor mode entry control block.
// Assumes inclusion by bare name from shared/ on the include path.
`ifndef MMEC_REGS_SVH
`define MMEC_REGS_SVH
`define MMEC_CLK_HZ 250000000
`define MMEC_BAUD 9600
`define MMEC_BIT_CYCLES (`MMEC_CLK_HZ / `MMEC_BAUD)
`define MMEC_SEC_BYTES 8
`define MMEC_BREAK_BITS 10
`define MMEC_BREAK_ZERO_BITS 9
`define MMEC_FRAME_BITS 10
`define MMEC_ECHO_GAP_BITS 2
`define MMEC_RESET_VEC_USER 16'hFFFE
`define MMEC_SWI_VEC_USER 16'hFFFC
`define MMEC_RESET_VEC_MON 16'hFEFE
`define MMEC_SWI_VEC_MON 16'hFEFC
`define MMEC_ENTRY_A2 1'h0
`define MMEC_ENTRY_A1 1'h1
`define MMEC_ENTRY_LINK 1'h1
`define MMEC_DIV_BY2 2'h1
`define MMEC_DIV_BY4 2'h2
`define MMEC_DIV_PLL 2'h3
`define MMEC_DIV_STOP 2'h0
`endif

// *** shared/mmec_pkg.sv ***
// Types for the monitor mode entry control block.
// Assumes mmec_regs.svh supplies the numeric constants.
package mmec_pkg;
  typedef struct packed {
    logic test_voltage_irq;
    logic test_voltage_reset;
    logic irq_low;
    logic entry_select_a2;
    logic entry_select_a1;
    logic clock_divider_select;
    logic reset_vector_blank;
  } mmec_straps_t;
  typedef struct packed {
    logic debug_monitor_mode;
    logic blank_entry;
    logic watchdog_disable;
    logic bus_clock_run;
    logic [1:0] clock_divide;
    logic pll_enable;
  } mmec_mode_t;
  typedef enum logic [3:0] {
    MMEC_SEC = 4'h1,
    MMEC_TXBRK = 4'h2,
    MMEC_READY = 4'h4,
    MMEC_BRKGAP = 4'h8
  } mmec_state_t;
endpackage : mmec_pkg

// *** core/mmec_rx.sv ***
// Serial receiver for the monitor link: start, eight data bits LSB first, stop.
// Assumes the line input is synchronous to clk.
`timescale 1ns/1ns
`include "mmec_regs.svh"
module mmec_rx #(
  parameter int BIT_CYCLES = `MMEC_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line_in,
  output logic [7:0] byte_data,
  output logic byte_valid,
  output logic break_seen
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bit_cycles_check
    $error("BIT_CYCLES out of range");
  end
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [8:0] shift_reg;
  logic busy_reg;
  logic line_prev_reg;
  logic valid_reg;
  logic brk_reg;
  logic [7:0] data_reg;
  wire logic bit_end = (cnt_reg == 16'(BIT_CYCLES - 1));
  wire logic mid = (cnt_reg == 16'(BIT_CYCLES / 2));
  wire logic frame_done = busy_reg && mid && (bit_reg == 4'(`MMEC_FRAME_BITS - 1));
  // framing; break is start plus nine zeros with no stop bit.
  always_ff @(posedge clk) begin
    valid_reg <= 1'b0;
    brk_reg <= 1'b0;
    line_prev_reg <= line_in;
    if (!reset_n) begin
      line_prev_reg <= 1'b1;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 9'h000;
      busy_reg <= 1'b0;
      data_reg <= 8'h00;
    end else if (!busy_reg) begin
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      // A start needs a falling edge, so the low tail of a break is never read as a new frame.
      busy_reg <= !line_in && line_prev_reg;
    end else begin
      cnt_reg <= bit_end ? 16'h0000 : cnt_reg + 16'h0001;
      if (mid && bit_reg != 4'h0)
        shift_reg <= {line_in, shift_reg[8:1]};
      if (bit_end)
        bit_reg <= bit_reg + 4'h1;
      if (frame_done) begin
        busy_reg <= 1'b0;
        if (line_in) begin
          valid_reg <= 1'b1;
          data_reg <= shift_reg[8:1];
        end else if (shift_reg[8:1] == 8'h00)
          brk_reg <= 1'b1;
      end
    end
  end
  assign byte_data = data_reg;
  assign byte_valid = valid_reg;
  assign break_seen = brk_reg;
endmodule : mmec_rx

// *** core/mmec_tx.sv ***
// Serial transmitter for the monitor link; pulls the wired-OR line low only.
// Assumes an external pull-up restores the line when released.
`timescale 1ns/1ns
`include "mmec_regs.svh"
module mmec_tx #(
  parameter int BIT_CYCLES = `MMEC_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic send,
  input wire logic send_break,
  input wire logic [7:0] send_data,
  output logic busy,
  output logic line_low
);
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bit_cycles_check
    $error("BIT_CYCLES out of range");
  end
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [9:0] shift_reg;
  logic busy_reg;
  wire logic bit_end = (cnt_reg == 16'(BIT_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 10'h3FF;
      busy_reg <= 1'b0;
    end else if (!busy_reg) begin
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      if (send || send_break) begin
        busy_reg <= 1'b1;
        // A break is ten zero bits, a character is start, data LSB first, stop.
        shift_reg <= send_break ? 10'h000 : {1'b1, send_data, 1'b0};
      end
    end else begin
      cnt_reg <= bit_end ? 16'h0000 : cnt_reg + 16'h0001;
      if (bit_end) begin
        shift_reg <= {1'b1, shift_reg[9:1]};
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'(`MMEC_BREAK_BITS - 1))
          busy_reg <= 1'b0;
      end
    end
  end
  assign busy = busy_reg;
  assign line_low = busy_reg && !shift_reg[0];
endmodule : mmec_tx

// *** bench/mmec_top_props.sv ***
// Concurrent checks on the ports of mmec_top.
// Assumes the bind below and a BIT_CYCLES equal to that of the bound design.
`timescale 1ns/1ns
module mmec_top_props #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic power_on_reset,
  input wire logic reset_pin,
  input mmec_pkg::mmec_straps_t straps,
  input wire logic serial_link_pin_in,
  input wire logic serial_link_pin_out,
  input wire logic serial_link_pin_oe,
  input mmec_pkg::mmec_mode_t mode,
  input wire logic [15:0] reset_vector_addr,
  input wire logic [15:0] swi_vector_addr,
  input wire logic security_done,
  input wire logic command_ready,
  input wire logic command_valid
);
  // ****************************************
  // Entry, vectors, watchdog and link checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int unsigned low_run;
  // Every pull of the line by the device is a break, so each low run has one fixed length.
  always_ff @(posedge clk) begin
    low_run <= serial_link_pin_oe ? low_run + 1 : 0;
  end
  sequence s_rise;
    $rose(reset_pin) && !power_on_reset;
  endsequence
  sequence s_tst_entry;
    s_rise ##0 (straps.test_voltage_irq && !straps.entry_select_a2 && straps.entry_select_a1
      && serial_link_pin_in && !mode.blank_entry);
  endsequence
  a_stop_in_reset: assert property (!reset_pin |-> mode.watchdog_disable && !mode.bus_clock_run
    && mode.clock_divide == 2'h0) else $error("bus clock or watchdog active in reset");
  a_vector_relocate: assert property (reset_vector_addr == (mode.debug_monitor_mode ? 16'hFEFE : 16'hFFFE)
    && swi_vector_addr == (mode.debug_monitor_mode ? 16'hFEFC : 16'hFFFC)) else $error("wrong vector");
  a_wdog_hold: assert property (mode.debug_monitor_mode && (straps.test_voltage_irq
    || straps.test_voltage_reset) |-> mode.watchdog_disable) else $error("watchdog enabled");
  a_strap_by_two: assert property (s_tst_entry ##0 !straps.clock_divider_select
    |=> mode.debug_monitor_mode && mode.clock_divide == 2'h1) else $error("no divide by two entry");
  a_strap_by_four: assert property (s_tst_entry ##0 straps.clock_divider_select
    |=> mode.debug_monitor_mode && mode.clock_divide == 2'h2) else $error("no divide by four entry");
  a_blank_loop: assert property (s_rise ##0 (!straps.test_voltage_irq && straps.reset_vector_blank)
    |=> mode.blank_entry && mode.clock_divide == 2'h3) else $error("blank entry without loop");
  a_blank_keep: assert property (s_rise ##0 mode.blank_entry |=> mode.debug_monitor_mode)
    else $error("blank entry left by reset pin");
  a_quiet_secure: assert property (!security_done |-> !serial_link_pin_oe && !command_ready
    && !command_valid) else $error("activity before security bytes");
  a_pull_low_only: assert property (serial_link_pin_out == 1'b0) else $error("link driven high");
  a_break_len: assert property ($fell(serial_link_pin_oe) |-> low_run == 10 * BIT_CYCLES)
    else $error("break length wrong");
endmodule : mmec_top_props
bind mmec_top mmec_top_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (.clk(clk), .reset_n(reset_n),
  .power_on_reset(power_on_reset), .reset_pin(reset_pin), .straps(straps), .serial_link_pin_in(serial_link_pin_in),
  .serial_link_pin_out(serial_link_pin_out), .serial_link_pin_oe(serial_link_pin_oe), .mode(mode),
  .reset_vector_addr(reset_vector_addr), .swi_vector_addr(swi_vector_addr), .security_done(security_done),
  .command_ready(command_ready), .command_valid(command_valid));

// *** bench/mmec_host.sv ***
// Host model on the far side of the monitor link.
// Assumes the bench resolves the wired-OR line with a pull-up.
`timescale 1ns/1ns
module mmec_host #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk,
  output logic line_low
);
  // ****************************************
  // Frame sender
  // ****************************************
  initial line_low = 1'b0;
  // Ten bits LSB first at the device's bit rate, then one idle bit.
  task automatic send_frame(input logic [9:0] frame);
    for (int i = 0; i < 10; i++) begin
      line_low <= !frame[i];
      repeat (BIT_CYCLES) @(negedge clk);
    end
    line_low <= 1'b0;
    repeat (BIT_CYCLES) @(negedge clk);
  endtask : send_frame
endmodule : mmec_host

// *** bench/tb_mmec_top.sv ***
// Self-checking bench for mmec_top: entries, security wait, breaks and commands.
// Assumes mmec_host on the link and the checker bound from its own file.
`timescale 1ns/1ns
module tb_mmec_top;
  // ****************************************
  // Bench
  // ****************************************
  localparam int BC = 8;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_on_reset = 1'b0;
  logic reset_pin = 1'b0;
  mmec_pkg::mmec_straps_t straps = '0;
  mmec_pkg::mmec_mode_t mode;
  logic host_low, link, oe, pin_out, sec_done, cmd_ready, cmd_valid;
  logic [15:0] rvec, svec;
  logic [7:0] cmd_data, b;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  int len, gap;
  initial forever #2 clk = ~clk;
  assign link = !(oe | host_low);
  mmec_top #(.BIT_CYCLES(BC)) DUT (.clk(clk), .reset_n(reset_n), .power_on_reset(power_on_reset),
    .reset_pin(reset_pin), .straps(straps), .serial_link_pin_in(link), .serial_link_pin_out(pin_out),
    .serial_link_pin_oe(oe), .mode(mode), .reset_vector_addr(rvec), .swi_vector_addr(svec),
    .security_done(sec_done), .command_ready(cmd_ready), .command_data(cmd_data), .command_valid(cmd_valid));
  mmec_host #(.BIT_CYCLES(BC)) host (.clk(clk), .line_low(host_low));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Straps stay put after the pulse, so entry_select_a1 holds through security.
  task automatic enter(input logic tvi, input logic cds, input logic blank);
    reset_pin <= 1'b0;
    straps <= {tvi, 1'b0, !tvi, 1'b0, 1'b1, cds, blank};
    repeat (3) @(negedge clk);
    check("reset_hold", {mode.watchdog_disable, mode.bus_clock_run, mode.clock_divide}, 16'h8);
    reset_pin <= 1'b1;
    repeat (3) @(negedge clk);
  endtask : enter
  // Bounded wait for the device to pull the line, then the length of the pull.
  task automatic low_len();
    gap = 0;
    len = 0;
    while (oe !== 1'b1 && gap < 4000) begin
      @(negedge clk);
      gap++;
    end
    while (oe === 1'b1 && len < 4000) begin
      @(negedge clk);
      len++;
    end
  endtask : low_len
  always @(negedge clk) begin
    if (reset_n && cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("cmd_unexpected", 16'h1, 16'h0);
      else check("cmd_data", {8'h0, cmd_data}, {8'h0, exp_q.pop_front()});
    end
  end
  // Traffic takes some 1300 clocks; this limit of 25000 clocks is near twenty times that.
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(75578));
    repeat (6) @(negedge clk);
    reset_n <= 1'b1;
    enter(1'b0, 1'($urandom), 1'b0);
    check("user", {mode.debug_monitor_mode, mode.watchdog_disable}, 16'h0);
    check("user_vec", rvec ^ svec, 16'hFFFE ^ 16'hFFFC);
    check("user_rvec", rvec, 16'hFFFE);
    enter(1'b1, 1'b0, 1'b0);
    check("mon_by2", {mode.debug_monitor_mode, mode.watchdog_disable, mode.clock_divide}, 16'hD);
    check("mon_rvec", rvec, 16'hFEFE);
    check("mon_svec", svec, 16'hFEFC);
    for (int i = 0; i < 7; i++) begin
      host.send_frame({1'b1, 8'($urandom), 1'b0});
      check("secure_wait", {sec_done, cmd_ready}, 16'h0);
    end
    fork
      host.send_frame({1'b1, 8'($urandom), 1'b0});
      low_len();
    join
    check("sec_break", 16'(len), 16'(10 * BC));
    repeat (4) @(negedge clk);
    check("ready", {15'h0, cmd_ready}, 16'h1);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      exp_q.push_back(b);
      host.send_frame({1'b1, b, 1'b0});
    end
    fork
      host.send_frame(10'h000);
      low_len();
    join
    check("echo_len", 16'(len), 16'(10 * BC));
    check("echo_gap", {15'h0, gap >= 11 * BC && gap <= 13 * BC}, 16'h1);
    check("cmd_left", 16'(exp_q.size()), 16'h0);
    straps.test_voltage_reset <= 1'b1;
    @(negedge clk);
    straps.test_voltage_irq <= 1'b0;
    repeat (2) @(negedge clk);
    check("wdog_tst_reset", {15'h0, mode.watchdog_disable}, 16'h1);
    straps.test_voltage_reset <= 1'b0;
    repeat (2) @(negedge clk);
    check("wdog_released", {15'h0, mode.watchdog_disable}, 16'h0);
    enter(1'b1, 1'b1, 1'b0);
    check("mon_by4", {mode.debug_monitor_mode, mode.clock_divide}, 16'h6);
    enter(1'b0, 1'($urandom), 1'b1);
    check("blank", {mode.debug_monitor_mode, mode.blank_entry, mode.clock_divide, mode.pll_enable}, 16'h1F);
    enter(1'b0, 1'b0, 1'b0);
    check("blank_kept", {15'h0, mode.debug_monitor_mode}, 16'h1);
    power_on_reset <= 1'b1;
    repeat (2) @(negedge clk);
    power_on_reset <= 1'b0;
    enter(1'b0, 1'b0, 1'b0);
    check("por_exit", {15'h0, mode.debug_monitor_mode}, 16'h0);
    finish_test();
  end
endmodule : tb_mmec_top
